// ---- verilog/sdram_command_pdt_port.sv ----
// sdram command issue and peripheral transfer strobe, register side on clk_i
`timescale 1ns/1ps
`default_nettype none
module sdram_command_pdt_port #(
	parameter bit WIDE_PORT = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [sdram_pdt_pkg::REG_AW-1:0] reg_addr_i,
	input wire logic [sdram_pdt_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [sdram_pdt_pkg::DATA_W-1:0] reg_rdata_o,
	input wire logic mem_clk_i,
	output sdram_pdt_pkg::sdram_pins_s sdram_cmd_o,
	output logic [sdram_pdt_pkg::ADDR_W-1:0] memory_address_bus_o,
	output logic [sdram_pdt_pkg::BANK_W-1:0] sdram_bank_o,
	output logic [sdram_pdt_pkg::DATA_W-1:0] memory_data_bus_o,
	output logic memory_data_bus_oe_o,
	input wire logic [sdram_pdt_pkg::DATA_W-1:0] memory_data_bus_i,
	output logic peripheral_transfer_strobe_o,
	output logic sdram_clock_enable_out_o
);
	import sdram_pdt_pkg::*;

	typedef enum logic [2:0] {
		L_IDLE = 3'h0,
		L_DECIDE = 3'h1,
		L_CLOSE = 3'h2,
		L_OPEN = 3'h3,
		L_ISSUE = 3'h4,
		L_RDWAIT = 3'h5,
		L_DONE = 3'h6
	} link_state_e;

	function automatic logic [NBANK-1:0] bank_onehot(
		input logic [BANK_W-1:0] b
	);
		bank_onehot = NBANK'(1) << b;
	endfunction : bank_onehot

	// ---------------- register side (clk_i) ----------------
	logic [4:0] ctrl_q;
	cmd_req_s req_q;
	logic [ADDR_W-1:0] row_reg_q;
	logic [ADDR_W-1:0] col_reg_q;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] rdata_q;
	logic req_tgl_q;
	logic busy_q;
	logic refused_q;
	logic ack_s1_q;
	logic ack_s2_q;
	logic ack_s3_q;
	logic ack_tgl_q;
	logic [DATA_W-1:0] link_rdata_q;
	logic ack_seen;
	logic cmd_wr;

	assign ack_seen = ack_s2_q ^ ack_s3_q;
	assign cmd_wr = reg_wr_i && reg_addr_i == REG_CMD_OFS;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q <= CTRL_RST;
			row_reg_q <= '0;
			col_reg_q <= '0;
			wdata_q <= '0;
		end else if (reg_wr_i) begin
			if (reg_addr_i == REG_CTRL_OFS) begin
				ctrl_q <= reg_wdata_i[4:0];
			end
			if (reg_addr_i == REG_ADDR_OFS) begin
				row_reg_q <= reg_wdata_i[ADDR_ROW_LSB +: ADDR_W];
				col_reg_q <= reg_wdata_i[ADDR_COL_LSB +: ADDR_W];
			end
			if (reg_addr_i == REG_WDATA_OFS) begin
				wdata_q <= reg_wdata_i;
			end
		end
	end

	// snapshot stays still while busy, so the link side may read it freely
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			req_q <= '0;
			req_tgl_q <= 1'b0;
		end else if (cmd_wr && !busy_q) begin
			req_q.kind <= cmd_kind_e'(reg_wdata_i[CMD_KIND_LSB +: 3]);
			req_q.mode_bit <= reg_wdata_i[CMD_MODE_BIT];
			req_q.bank <= reg_wdata_i[CMD_BANK_LSB +: BANK_W];
			req_q.row <= row_reg_q;
			req_q.col <= col_reg_q;
			req_q.wdata <= wdata_q;
			req_q.rlat <= ctrl_q[CTRL_RLAT_LSB +: 2];
			req_q.wlat <= ctrl_q[CTRL_WLAT_LSB +: 2];
			req_tgl_q <= ~req_tgl_q;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			ack_s3_q <= 1'b0;
		end else begin
			ack_s1_q <= ack_tgl_q;
			ack_s2_q <= ack_s1_q;
			ack_s3_q <= ack_s2_q;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_q <= 1'b0;
		end else if (cmd_wr && !busy_q) begin
			busy_q <= 1'b1;
		end else if (ack_seen) begin
			busy_q <= 1'b0;
		end
	end

	// a refusal in the cycle of its clear still sticks
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			refused_q <= 1'b0;
		end else if (cmd_wr && busy_q) begin
			refused_q <= 1'b1;
		end else if (reg_wr_i && reg_addr_i == REG_STATUS_OFS &&
			reg_wdata_i[STAT_REFUSED_BIT]) begin
			refused_q <= 1'b0;
		end
	end

	// link word is stable from one ack until the next read's data edge
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_q <= '0;
		end else if (ack_seen) begin
			rdata_q <= link_rdata_q;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				REG_CTRL_OFS: reg_rdata_o <= {27'h0, ctrl_q};
				REG_ADDR_OFS: reg_rdata_o <= {3'h0, col_reg_q, 3'h0, row_reg_q};
				REG_WDATA_OFS: reg_rdata_o <= wdata_q;
				REG_RDATA_OFS: reg_rdata_o <= rdata_q;
				REG_STATUS_OFS: reg_rdata_o <= {30'h0, refused_q, busy_q};
				default: reg_rdata_o <= '0;
			endcase
		end else begin
			reg_rdata_o <= '0;
		end
	end

	// ---------------- link side (mem_clk_i) ----------------
	logic lrst_s1_q;
	logic lrst_b_q;
	logic rq_s1_q;
	logic rq_s2_q;
	logic rq_s3_q;
	logic cke_s1_q;
	cmd_req_s lc_q;
	link_state_e st_q;
	link_state_e st_d;
	logic [NBANK-1:0] open_q;
	logic [ADDR_W-1:0] open_row_q [NBANK];
	sdram_pins_s pins_d;
	logic [ADDR_W-1:0] addr_d;
	logic [3:0] rd_pipe_q;
	logic [2:0] dl_q;
	logic ev;
	logic pdt_d;
	logic [1:0] cur_lat;
	logic is_rw;
	logic all_close;
	logic new_req;

	assign new_req = rq_s2_q ^ rq_s3_q;
	assign is_rw = lc_q.kind == K_READ || lc_q.kind == K_WRITE;
	assign all_close = lc_q.kind == K_REFRESH || lc_q.kind == K_MODE_SET;

	// reset asserts at once, releases on the link clock
	always_ff @(posedge mem_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lrst_s1_q <= 1'b0;
			lrst_b_q <= 1'b0;
		end else begin
			lrst_s1_q <= 1'b1;
			lrst_b_q <= lrst_s1_q;
		end
	end

	always_ff @(posedge mem_clk_i or negedge lrst_b_q) begin
		if (!lrst_b_q) begin
			rq_s1_q <= 1'b0;
			rq_s2_q <= 1'b0;
			rq_s3_q <= 1'b0;
			cke_s1_q <= 1'b0;
			sdram_clock_enable_out_o <= 1'b0;
		end else begin
			rq_s1_q <= req_tgl_q;
			rq_s2_q <= rq_s1_q;
			rq_s3_q <= rq_s2_q;
			cke_s1_q <= ctrl_q[CTRL_CKE_BIT];
			sdram_clock_enable_out_o <= WIDE_PORT & cke_s1_q;
		end
	end

	always_ff @(posedge mem_clk_i or negedge lrst_b_q) begin
		if (!lrst_b_q) begin
			lc_q <= '0;
		end else if (st_q == L_IDLE && new_req) begin
			lc_q <= req_q;
		end
	end

	always_comb begin
		st_d = st_q;
		pins_d = PINS_DESEL;
		addr_d = '0;
		unique case (st_q)
			L_IDLE: begin
				if (new_req) begin
					st_d = L_DECIDE;
				end
			end
			L_DECIDE: begin
				pins_d = PINS_NOP;
				if (lc_q.kind == K_NONE) begin
					st_d = L_DONE;
				end else if (is_rw) begin
					if (!open_q[lc_q.bank]) begin
						st_d = L_OPEN;
					end else if (open_row_q[lc_q.bank] != lc_q.row) begin
						st_d = L_CLOSE;
					end else begin
						st_d = L_ISSUE;
					end
				end else if (all_close) begin
					st_d = (|open_q) ? L_CLOSE : L_ISSUE;
				end else if (lc_q.kind == K_ACTIVATE) begin
					st_d = open_q[lc_q.bank] ? L_CLOSE : L_ISSUE;
				end else begin
					st_d = L_ISSUE;
				end
			end
			L_CLOSE: begin
				pins_d = PINS_PRECH;
				addr_d[AUTO_CLOSE_BIT] = all_close;
				st_d = L_DECIDE;
			end
			L_OPEN: begin
				pins_d = PINS_ACT;
				addr_d = lc_q.row;
				st_d = L_DECIDE;
			end
			L_ISSUE: begin
				st_d = L_DONE;
				unique case (lc_q.kind)
					K_READ: begin
						pins_d = PINS_READ;
						addr_d = lc_q.col;
						addr_d[AUTO_CLOSE_BIT] = 1'b0;
						st_d = L_RDWAIT;
					end
					K_WRITE: begin
						pins_d = PINS_WRITE;
						addr_d = lc_q.col;
						addr_d[AUTO_CLOSE_BIT] = 1'b0;
					end
					K_ACTIVATE: begin
						pins_d = PINS_ACT;
						addr_d = lc_q.row;
					end
					K_DEACT_BANK: begin
						pins_d = PINS_PRECH;
					end
					K_DEACT_ALL: begin
						pins_d = PINS_PRECH;
						addr_d[AUTO_CLOSE_BIT] = 1'b1;
					end
					K_REFRESH: pins_d = PINS_AUTO_REFRESH_CMD;
					K_MODE_SET: begin
						pins_d = PINS_MRS;
						addr_d = lc_q.row;
					end
					default: pins_d = PINS_NOP;
				endcase
			end
			L_RDWAIT: begin
				pins_d = PINS_NOP;
				if (rd_pipe_q[CAS_LATENCY]) begin
					st_d = L_DONE;
				end
			end
			L_DONE: st_d = L_IDLE;
			default: st_d = L_IDLE;
		endcase
	end

	always_ff @(posedge mem_clk_i or negedge lrst_b_q) begin
		if (!lrst_b_q) begin
			st_q <= L_IDLE;
			sdram_cmd_o <= PINS_DESEL;
			memory_address_bus_o <= '0;
			sdram_bank_o <= '0;
		end else begin
			st_q <= st_d;
			sdram_cmd_o <= pins_d;
			memory_address_bus_o <= addr_d;
			sdram_bank_o <= lc_q.bank;
		end
	end

	// bank bookkeeping mirrors what the pins just told the memory
	always_ff @(posedge mem_clk_i or negedge lrst_b_q) begin
		if (!lrst_b_q) begin
			open_q <= '0;
		end else if (st_q == L_CLOSE) begin
			open_q <= all_close ? '0 : (open_q & ~bank_onehot(lc_q.bank));
		end else if (st_q == L_OPEN ||
			(st_q == L_ISSUE && lc_q.kind == K_ACTIVATE)) begin
			open_q <= open_q | bank_onehot(lc_q.bank);
		end else if (st_q == L_ISSUE && lc_q.kind == K_DEACT_BANK) begin
			open_q <= open_q & ~bank_onehot(lc_q.bank);
		end else if (st_q == L_ISSUE && lc_q.kind == K_DEACT_ALL) begin
			open_q <= '0;
		end
	end

	always_ff @(posedge mem_clk_i) begin
		if (st_q == L_OPEN || (st_q == L_ISSUE && lc_q.kind == K_ACTIVATE)) begin
			open_row_q[lc_q.bank] <= lc_q.row;
		end
	end

	// write data sits on the bus always; its drive enable rides with the write command only, and only when mode_bit is clear
	always_ff @(posedge mem_clk_i or negedge lrst_b_q) begin
		if (!lrst_b_q) begin
			memory_data_bus_o <= '0;
			memory_data_bus_oe_o <= 1'b0;
		end else begin
			memory_data_bus_o <= lc_q.wdata;
			memory_data_bus_oe_o <= st_q == L_ISSUE && lc_q.kind == K_WRITE &&
				!lc_q.mode_bit;
		end
	end

	always_ff @(posedge mem_clk_i or negedge lrst_b_q) begin
		if (!lrst_b_q) begin
			rd_pipe_q <= '0;
		end else begin
			rd_pipe_q <= {rd_pipe_q[2:0], st_q == L_ISSUE && lc_q.kind == K_READ};
		end
	end

	// bus is synchronous to the link clock, sampled once at the data edge of a read without mode_bit
	always_ff @(posedge mem_clk_i or negedge lrst_b_q) begin
		if (!lrst_b_q) begin
			link_rdata_q <= '0;
		end else if (st_q == L_RDWAIT && rd_pipe_q[CAS_LATENCY] &&
			!lc_q.mode_bit) begin
			link_rdata_q <= memory_data_bus_i;
		end
	end

	always_ff @(posedge mem_clk_i or negedge lrst_b_q) begin
		if (!lrst_b_q) begin
			ack_tgl_q <= 1'b0;
		end else if (st_q == L_DONE) begin
			ack_tgl_q <= ~ack_tgl_q;
		end
	end

	// ev marks the cycle before the data phase, so the strobe flop lines up
	assign ev = lc_q.mode_bit && ((st_q == L_ISSUE && lc_q.kind == K_WRITE) ||
		(st_q == L_RDWAIT && rd_pipe_q[CAS_LATENCY-1]));
	assign cur_lat = (lc_q.kind == K_WRITE) ? lc_q.wlat : lc_q.rlat;

	always_comb begin
		unique case (cur_lat)
			2'h0: pdt_d = ev;
			2'h1: pdt_d = dl_q[0];
			2'h2: pdt_d = dl_q[1];
			2'h3: pdt_d = dl_q[2];
		endcase
	end

	always_ff @(posedge mem_clk_i or negedge lrst_b_q) begin
		if (!lrst_b_q) begin
			dl_q <= '0;
			peripheral_transfer_strobe_o <= 1'b0;
		end else begin
			dl_q <= {dl_q[1:0], ev};
			peripheral_transfer_strobe_o <= pdt_d;
		end
	end

	// ---------------- checks ----------------
	sequence s_read_issued;
		st_q == L_ISSUE && lc_q.kind == K_READ;
	endsequence
	sequence s_data_edge;
		st_q == L_RDWAIT && rd_pipe_q[CAS_LATENCY];
	endsequence

	chk_read_cas_three: assert property (@(posedge mem_clk_i)
		disable iff (!lrst_b_q) s_read_issued |-> ##4 s_data_edge)
		else $error("read data edge not four edges after issue");
	chk_no_capture_pdt: assert property (@(posedge mem_clk_i)
		disable iff (!lrst_b_q) (s_data_edge and lc_q.mode_bit) |=>
		$stable(link_rdata_q))
		else $error("transfer-mode read captured data");
	chk_strobe_lat_zero: assert property (@(posedge mem_clk_i)
		disable iff (!lrst_b_q) (ev && cur_lat == 2'h0) |=>
		peripheral_transfer_strobe_o)
		else $error("zero latency strobe missing");
	chk_strobe_lat_three: assert property (@(posedge mem_clk_i)
		disable iff (!lrst_b_q) (ev && cur_lat == 2'h3) |->
		##3 !peripheral_transfer_strobe_o ##1 peripheral_transfer_strobe_o)
		else $error("three cycle latency strobe wrong");
	chk_strobe_gated: assert property (@(posedge mem_clk_i)
		disable iff (!lrst_b_q) (st_q == L_ISSUE && !lc_q.mode_bit) |->
		##1 (!peripheral_transfer_strobe_o) [*7])
		else $error("strobe raised without mode bit");
	chk_write_float: assert property (@(posedge mem_clk_i)
		disable iff (!lrst_b_q) (st_q == L_ISSUE && lc_q.kind == K_WRITE) |=>
		(memory_data_bus_oe_o == !$past(lc_q.mode_bit)))
		else $error("write drive enable wrong for mode");
	chk_row_open_first: assert property (@(posedge mem_clk_i)
		disable iff (!lrst_b_q) (st_q == L_ISSUE && is_rw) |->
		open_q[lc_q.bank] && open_row_q[lc_q.bank] == lc_q.row)
		else $error("access to a row that is not open");
	chk_deactivate_bank_cmd_one_bank: assert property (@(posedge mem_clk_i)
		disable iff (!lrst_b_q) (st_q == L_ISSUE && lc_q.kind == K_DEACT_BANK)
		|=> open_q == ($past(open_q) & ~bank_onehot($past(lc_q.bank))) &&
		sdram_cmd_o == PINS_PRECH && !memory_address_bus_o[AUTO_CLOSE_BIT] &&
		sdram_bank_o == $past(lc_q.bank))
		else $error("single bank close touched other banks");
	chk_refresh_closed: assert property (@(posedge mem_clk_i)
		disable iff (!lrst_b_q) sdram_cmd_o == PINS_AUTO_REFRESH_CMD |-> open_q == '0)
		else $error("refresh with a bank open");
	chk_mrs_encoding: assert property (@(posedge mem_clk_i)
		disable iff (!lrst_b_q) (st_q == L_ISSUE && lc_q.kind == K_MODE_SET)
		|=> sdram_cmd_o == PINS_MRS && memory_address_bus_o == $past(lc_q.row))
		else $error("mode set not encoded on strobes");
	chk_cke_narrow: assert property (@(posedge mem_clk_i)
		disable iff (!lrst_b_q) !WIDE_PORT |-> !sdram_clock_enable_out_o)
		else $error("narrow port drove clock enable");
endmodule : sdram_command_pdt_port
`default_nettype wire

// ---- verilog/sdram_pdt_pkg.sv ----
// constants, command codes and carriers for the sdram command / transfer port
`default_nettype none
package sdram_pdt_pkg;
	localparam int REG_AW = 4;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 13;
	localparam int BANK_W = 2;
	localparam int NBANK = 4;
	localparam logic [3:0] REG_CTRL_OFS = 4'h0;
	localparam logic [3:0] REG_CMD_OFS = 4'h1;
	localparam logic [3:0] REG_ADDR_OFS = 4'h2;
	localparam logic [3:0] REG_WDATA_OFS = 4'h3;
	localparam logic [3:0] REG_RDATA_OFS = 4'h4;
	localparam logic [3:0] REG_STATUS_OFS = 4'h5;
	localparam int CTRL_RLAT_LSB = 0;
	localparam int CTRL_WLAT_LSB = 2;
	localparam int CTRL_CKE_BIT = 4;
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam int CMD_KIND_LSB = 0;
	localparam int CMD_MODE_BIT = 3;
	localparam int CMD_BANK_LSB = 4;
	localparam int ADDR_ROW_LSB = 0;
	localparam int ADDR_COL_LSB = 16;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_REFUSED_BIT = 1;
	localparam int AUTO_CLOSE_BIT = 10;
	localparam int CAS_LATENCY = 3;
	typedef enum logic [2:0] {
		K_READ = 3'h0,
		K_WRITE = 3'h1,
		K_ACTIVATE = 3'h2,
		K_DEACT_BANK = 3'h3,
		K_DEACT_ALL = 3'h4,
		K_REFRESH = 3'h5,
		K_MODE_SET = 3'h6,
		K_NONE = 3'h7
	} cmd_kind_e;
	typedef struct packed {
		logic cs_b;
		logic sdram_row_strobe_b;
		logic sdram_column_strobe_b;
		logic sdram_write_strobe_b;
	} sdram_pins_s;
	localparam sdram_pins_s PINS_DESEL = 4'hF;
	localparam sdram_pins_s PINS_NOP = 4'h7;
	localparam sdram_pins_s PINS_ACT = 4'h3;
	localparam sdram_pins_s PINS_READ = 4'h5;
	localparam sdram_pins_s PINS_WRITE = 4'h4;
	localparam sdram_pins_s PINS_PRECH = 4'h2;
	localparam sdram_pins_s PINS_AUTO_REFRESH_CMD = 4'h1;
	localparam sdram_pins_s PINS_MRS = 4'h0;
	typedef struct packed {
		cmd_kind_e kind;
		logic mode_bit;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] row;
		logic [ADDR_W-1:0] col;
		logic [DATA_W-1:0] wdata;
		logic [1:0] rlat;
		logic [1:0] wlat;
	} cmd_req_s;
endpackage : sdram_pdt_pkg
`default_nettype wire

// ---- sim/sdram_model.sv ----
// sdram device model sitting on the far side of the command port
`timescale 1ns/1ps
`default_nettype none
module sdram_model (
	input wire logic mem_clk_i,
	input wire logic rst_b_i,
	input wire sdram_pdt_pkg::sdram_pins_s cmd_i,
	input wire logic [sdram_pdt_pkg::ADDR_W-1:0] addr_i,
	input wire logic [sdram_pdt_pkg::BANK_W-1:0] bank_i,
	input wire logic [sdram_pdt_pkg::DATA_W-1:0] data_i,
	input wire logic oe_i,
	output logic [sdram_pdt_pkg::DATA_W-1:0] data_o,
	output int faults_o
);
	import sdram_pdt_pkg::*;
	logic [NBANK-1:0] open_q;
	logic [1:0] vld_q;
	logic [3:0] col_q [3];
	logic [DATA_W-1:0] mem_q [16];
	always_ff @(posedge mem_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			open_q <= '0;
			vld_q <= 2'h0;
			data_o <= '0;
			faults_o <= 0;
		end else begin
			vld_q <= {vld_q[0], cmd_i == PINS_READ};
			col_q[0] <= addr_i[3:0];
			col_q[1] <= col_q[0];
			col_q[2] <= col_q[1];
			// idle bus shows the inverse so stale data never matches
			data_o <= vld_q[1] ? mem_q[col_q[1]] : ~data_o;
			case (cmd_i)
				PINS_ACT: begin
					if (open_q[bank_i]) faults_o <= faults_o + 1;
					open_q[bank_i] <= 1'b1;
				end
				PINS_PRECH: begin
					if (addr_i[AUTO_CLOSE_BIT]) open_q <= '0;
					else open_q[bank_i] <= 1'b0;
				end
				PINS_READ, PINS_WRITE: begin
					if (!open_q[bank_i]) faults_o <= faults_o + 1;
					if (cmd_i == PINS_WRITE && oe_i) begin
						mem_q[addr_i[3:0]] <= data_i;
					end
				end
				PINS_AUTO_REFRESH_CMD, PINS_MRS: begin
					if (open_q != '0) faults_o <= faults_o + 1;
				end
				default: ;
			endcase
		end
	end
endmodule : sdram_model
`default_nettype wire

// ---- sim/sdram_command_pdt_port_test.sv ----
// self-checking bench for the sdram command and transfer strobe port
`timescale 1ns/1ps
`default_nettype none
module sdram_command_pdt_port_test;
	import sdram_pdt_pkg::*;
	typedef struct {
		cmd_kind_e kind;
		logic mode;
		logic [1:0] lat;
		logic [12:0] col;
		logic [31:0] wd;
		int dly;
		logic oe;
	} row_s;
	logic clk_i, mem_clk_i, rst_b, wr_s, rd_s, oe, cke_n;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, md_o, md_i, d;
	logic [12:0] maddr;
	logic [1:0] bank;
	logic strobe, cke;
	sdram_pins_s pins;
	int fails, samples_checked, faults, tick, mcyc;
	int act_n, ref_n, st_n, st_cyc, wr_cyc, rd_cyc, a0, n;
	logic oe_w, prech_all;
	logic [12:0] mrs_addr;
	row_s rows [11];
	sdram_command_pdt_port #(.WIDE_PORT(1'b1)) i_sdram_command_pdt_port (
		.clk_i(clk_i), .rst_b_i(rst_b), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
		.reg_rdata_o(rdata), .mem_clk_i(mem_clk_i), .sdram_cmd_o(pins),
		.memory_address_bus_o(maddr), .sdram_bank_o(bank),
		.memory_data_bus_o(md_o), .memory_data_bus_oe_o(oe),
		.memory_data_bus_i(md_i), .peripheral_transfer_strobe_o(strobe),
		.sdram_clock_enable_out_o(cke));
	sdram_command_pdt_port #(.WIDE_PORT(1'b0)) i_sdram_command_pdt_port_n (
		.clk_i(clk_i), .rst_b_i(rst_b), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
		.reg_rdata_o(), .mem_clk_i(mem_clk_i), .sdram_cmd_o(),
		.memory_address_bus_o(), .sdram_bank_o(),
		.memory_data_bus_o(), .memory_data_bus_oe_o(),
		.memory_data_bus_i(md_i), .peripheral_transfer_strobe_o(),
		.sdram_clock_enable_out_o(cke_n));
	sdram_model i_sdram_model (.mem_clk_i(mem_clk_i), .rst_b_i(rst_b),
		.cmd_i(pins), .addr_i(maddr), .bank_i(bank), .data_i(md_o),
		.oe_i(oe), .data_o(md_i), .faults_o(faults));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// link clock offset so its edges never line up with clk_i
	initial begin
		mem_clk_i = 1'b0;
		#7.3;
		forever #32 mem_clk_i = ~mem_clk_i;
	end
	always @(posedge mem_clk_i) begin
		if (pins == PINS_ACT) act_n++;
		if (pins == PINS_AUTO_REFRESH_CMD) ref_n++;
		if (pins == PINS_MRS) mrs_addr = maddr;
		if (pins == PINS_PRECH) prech_all = maddr[AUTO_CLOSE_BIT];
		if (pins == PINS_READ) rd_cyc = mcyc;
		if (pins == PINS_WRITE) begin
			wr_cyc = mcyc;
			oe_w = oe;
		end
		if (strobe) begin
			st_n++;
			st_cyc = mcyc;
		end
		mcyc++;
	end
	task automatic wrap_up;
		$display("checked %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up
	always @(posedge clk_i) begin
		tick++;
		if (tick == 60000) begin
			fails++;
			wrap_up();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic bus_write(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk_i);
		wr_s <= 1'b0;
	endtask : bus_write
	task automatic bus_read(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk_i);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_i);
		rd_s <= 1'b0;
		#1;
		v = rdata;
	endtask : bus_read
	task automatic wait_idle;
		logic [31:0] s;
		int k;
		s = 32'h1;
		k = 0;
		while (s[STAT_BUSY_BIT] !== 1'b0 && k < 200) begin
			bus_read(REG_STATUS_OFS, s);
			k++;
		end
		if (k == 200) fails++;
	endtask : wait_idle
	task automatic run_cmd(input cmd_kind_e k, input logic m,
		input logic [1:0] b, input logic [12:0] r, input logic [12:0] c,
		input logic [31:0] w);
		bus_write(REG_ADDR_OFS, {3'h0, c, 3'h0, r});
		bus_write(REG_WDATA_OFS, w);
		bus_write(REG_CMD_OFS, {26'h0, b, m, k});
		wait_idle();
		repeat (8) @(posedge mem_clk_i);
	endtask : run_cmd
	initial begin
		{rst_b, wr_s, rd_s, addr, wdata} = '0;
		rows[0] = '{K_WRITE, 1'b0, 2'h0, 13'h4, 32'h6677_8899, 0, 1'b1};
		rows[1] = '{K_WRITE, 1'b0, 2'h0, 13'h3, 32'h1122_3344, 0, 1'b1};
		rows[2] = '{K_READ, 1'b0, 2'h0, 13'h3, 32'h1122_3344, 0, 1'b0};
		for (int i = 0; i < 4; i++) begin
			rows[3+i] = '{K_WRITE, 1'b1, 2'(i), 13'h3, 32'hA5A5_0F0F, i, 1'b0};
			rows[7+i] = '{K_READ, 1'b1, 2'(i), 13'h4, 32'h1122_3344, 3+i, 1'b0};
		end
		// link side clears asynchronously, so clk_i cycles are enough
		repeat (5) @(posedge clk_i);
		rst_b <= 1'b1;
		repeat (30) @(posedge clk_i);
		foreach (rows[i]) begin
			bus_write(REG_CTRL_OFS, {28'h0, rows[i].lat, rows[i].lat});
			n = st_n;
			run_cmd(rows[i].kind, rows[i].mode, 2'h0, 13'h12, rows[i].col,
				rows[i].wd);
			check(st_n - n, {31'h0, rows[i].mode});
			if (rows[i].kind == K_WRITE) begin
				check({31'h0, oe_w}, {31'h0, rows[i].oe});
				if (rows[i].mode) check(st_cyc - wr_cyc, rows[i].dly);
			end else begin
				bus_read(REG_RDATA_OFS, d);
				check(d, rows[i].wd);
				if (rows[i].mode) check(st_cyc - rd_cyc, rows[i].dly);
			end
		end
		@(posedge clk_i);
		rst_b <= 1'b0;
		repeat (5) @(posedge mem_clk_i);
		check({28'h0, pins}, {28'h0, PINS_DESEL});
		@(posedge clk_i);
		rst_b <= 1'b1;
		repeat (30) @(posedge clk_i);
		bus_read(REG_CTRL_OFS, d);
		check(d, 32'h0);
		bus_read(4'hC, d);
		check(d, 32'h0);
		run_cmd(K_WRITE, 1'b0, 2'h1, 13'h5, 13'h1, 32'hCAFE_0001);
		run_cmd(K_WRITE, 1'b0, 2'h0, 13'h7, 13'h2, 32'hCAFE_0002);
		run_cmd(K_DEACT_BANK, 1'b0, 2'h0, 13'h0, 13'h0, 32'h0);
		check({31'h0, prech_all}, 32'h0);
		a0 = act_n;
		run_cmd(K_READ, 1'b0, 2'h1, 13'h5, 13'h1, 32'h0);
		check(act_n - a0, 0);
		bus_read(REG_RDATA_OFS, d);
		check(d, 32'hCAFE_0001);
		run_cmd(K_READ, 1'b0, 2'h0, 13'h7, 13'h2, 32'h0);
		check(act_n - a0, 1);
		run_cmd(K_DEACT_ALL, 1'b0, 2'h0, 13'h0, 13'h0, 32'h0);
		check({31'h0, prech_all}, 32'h1);
		a0 = act_n;
		run_cmd(K_READ, 1'b0, 2'h1, 13'h5, 13'h1, 32'h0);
		check(act_n - a0, 1);
		// activate on an open bank, then a row miss on that bank
		a0 = act_n;
		run_cmd(K_ACTIVATE, 1'b0, 2'h2, 13'h9, 13'h0, 32'h0);
		run_cmd(K_ACTIVATE, 1'b0, 2'h2, 13'hA, 13'h0, 32'h0);
		check({31'h0, prech_all}, 32'h0);
		run_cmd(K_READ, 1'b0, 2'h2, 13'h9, 13'h1, 32'h0);
		check(act_n - a0, 3);
		bus_read(REG_RDATA_OFS, d);
		check(d, 32'hCAFE_0001);
		n = ref_n;
		run_cmd(K_REFRESH, 1'b0, 2'h0, 13'h0, 13'h0, 32'h0);
		check(ref_n - n, 1);
		run_cmd(K_MODE_SET, 1'b0, 2'h0, 13'h0032, 13'h0, 32'h0);
		check({19'h0, mrs_addr}, 32'h32);
		run_cmd(K_NONE, 1'b0, 2'h0, 13'h0, 13'h0, 32'h0);
		// second launch lands while the first is still busy
		bus_write(REG_CMD_OFS, {29'h0, K_READ});
		bus_write(REG_CMD_OFS, {29'h0, K_READ});
		wait_idle();
		bus_read(REG_STATUS_OFS, d);
		check(d, 32'h2);
		bus_write(REG_STATUS_OFS, 32'h2);
		bus_read(REG_STATUS_OFS, d);
		check(d, 32'h0);
		bus_write(REG_CTRL_OFS, 32'h10);
		repeat (4) @(posedge mem_clk_i);
		check({31'h0, cke}, 32'h1);
		check({31'h0, cke_n}, 32'h0);
		bus_write(REG_CTRL_OFS, 32'h0);
		repeat (4) @(posedge mem_clk_i);
		check({31'h0, cke}, 32'h0);
		check(faults, 0);
		wrap_up();
	end
endmodule : sdram_command_pdt_port_test
`default_nettype wire
